// *** rtl/tsbm_battery_sampler.sv ***
// Purpose: Periodic battery sampling, threshold compare and four-reading filter
// Assumes: battery_code_in is analog-side data, stable late in the power window
// Notes:   Disabling the monitor clears all timing and filter state
`timescale 1ns/1ps
`default_nettype none
module tsbm_battery_sampler #(
  parameter int PERIOD_CYCLES = tsbm_pkg::BAT_PERIOD_CYCLES,
  parameter int WINDOW_CYCLES = tsbm_pkg::BAT_WINDOW_CYCLES
) (
  input  wire logic                            ref_clk,
  input  wire logic                            resetn,
  input  wire logic                            enable,
  input  wire logic [tsbm_pkg::BAT_CODE_W-1:0] threshold,
  input  wire logic [tsbm_pkg::BAT_CODE_W-1:0] battery_code_in,
  output logic                                 monitor_power,
  output logic [tsbm_pkg::BAT_CODE_W-1:0]      level,
  output logic                                 low_event
);

  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam int FW = $clog2(tsbm_pkg::BAT_FILTER_N + 1);

  typedef enum logic [1:0] {ST_WAIT, ST_MEASURE} tsbm_smp_state_t;

  tsbm_smp_state_t                       state_q;
  logic [CW-1:0]                         cnt_q;
  logic [FW-1:0]                         filt_q;
  logic [tsbm_pkg::BAT_CODE_W-1:0]       code_s1_q;
  logic [tsbm_pkg::BAT_CODE_W-1:0]       code_s2_q;
  logic [tsbm_pkg::BAT_CODE_W-1:0]       level_q;
  logic                                  event_q;

  wire period_end = (cnt_q == CW'(PERIOD_CYCLES - 1));
  wire window_end = (cnt_q == CW'(WINDOW_CYCLES - 1));
  wire sample_now = (state_q == ST_MEASURE) && window_end;
  wire is_low     = (code_s2_q <= threshold);
  wire filt_full  = (filt_q == FW'(tsbm_pkg::BAT_FILTER_N));

  // Two-flop capture of the analog code
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      code_s1_q <= '0;
      code_s2_q <= '0;
    end else begin
      code_s1_q <= battery_code_in;
      code_s2_q <= code_s1_q;
    end
  end

  // Sleep interval then power window, once per period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_WAIT;
      cnt_q   <= '0;
    end else if (!enable) begin
      state_q <= ST_WAIT;
      cnt_q   <= '0;
    end else if (state_q == ST_WAIT) begin
      state_q <= period_end ? ST_MEASURE : ST_WAIT;
      cnt_q   <= period_end ? '0 : cnt_q + 1'b1;
    end else begin
      state_q <= window_end ? ST_WAIT : ST_MEASURE;
      cnt_q   <= window_end ? CW'(WINDOW_CYCLES) : cnt_q + 1'b1;
    end
  end

  // Latest level, consecutive-low filter and event pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= '0;
      filt_q  <= '0;
      event_q <= 1'b0;
    end else begin
      event_q <= 1'b0;
      if (!enable) begin
        filt_q <= '0;
      end else if (sample_now) begin
        level_q <= code_s2_q;
        if (!is_low) begin
          filt_q <= '0;
        end else if (!filt_full) begin
          filt_q  <= filt_q + 1'b1;
          event_q <= (filt_q == FW'(tsbm_pkg::BAT_FILTER_N - 1));
        end
      end
    end
  end

  assign monitor_power = (state_q == ST_MEASURE);
  assign level         = level_q;
  assign low_event     = event_q;

endmodule
`default_nettype wire

// *** rtl/tsbm_pkg.sv ***
// Purpose: Shared constants for the temperature sensor and battery monitor block
// Assumes: 40 MHz ref_clk; register access through a port with 7-bit address and 8-bit data
// Notes:   All offsets, fields, resets and timing counts live here
package tsbm_pkg;

  // Register offsets (7-bit register address space)
  localparam logic [6:0] ADDR_CONV_CONFIG  = 7'h0f;
  localparam logic [6:0] ADDR_CONV_VALUE   = 7'h11;
  localparam logic [6:0] ADDR_TEMP_CTRL    = 7'h12;
  localparam logic [6:0] ADDR_TEMP_OFFSET  = 7'h13;
  localparam logic [6:0] ADDR_BAT_THRESH   = 7'h1a;
  localparam logic [6:0] ADDR_BAT_LEVEL    = 7'h1b;

  // Reset values
  localparam logic [7:0] RST_CONV_CONFIG   = 8'h00;
  localparam logic [7:0] RST_TEMP_CTRL     = 8'h20;
  localparam logic [7:0] RST_TEMP_OFFSET   = 8'h00;
  localparam logic [4:0] RST_BAT_THRESH    = 5'h14;

  // Converter configuration fields
  localparam int CONV_START_BIT = 7;
  localparam int CONV_SEL_LSB   = 4;
  localparam int CONV_REF_LSB   = 2;
  localparam int CONV_GAIN_LSB  = 0;
  localparam logic [2:0] CONV_SEL_TEMP = 3'h0;

  // Temperature sensor control fields
  localparam int TEMP_RANGE_LSB = 6;
  localparam int TEMP_SHIFT_BIT = 5;
  localparam int TEMP_TRIM_EN_BIT = 4;
  localparam int TEMP_TRIM_LSB  = 0;
  localparam logic [1:0] RANGE_C_0_128 = 2'h2;

  // Battery code width and filter depth
  localparam int BAT_CODE_W    = 5;
  localparam int BAT_FILTER_N  = 4;

  // Timing: times in their own units, counts derived at the 40 MHz rate
  localparam int REF_CLK_MHZ       = 40;
  localparam int BAT_PERIOD_US     = 1000000;
  localparam int BAT_WINDOW_US     = 250;
  localparam int CONV_TIME_US      = 350;
  localparam int BAT_PERIOD_CYCLES = BAT_PERIOD_US * REF_CLK_MHZ;
  localparam int BAT_WINDOW_CYCLES = BAT_WINDOW_US * REF_CLK_MHZ;
  localparam int CONV_TIME_CYCLES  = CONV_TIME_US * REF_CLK_MHZ;

endpackage

// *** rtl/tsbm_top.sv ***
// Purpose: Temperature sensor control, converter sequencing and battery monitor
// Assumes: Register port decoded from the serial interface on ref_clk;
//          mode and enable inputs come from same-clock logic
// Notes:   Analog-side converter results pass two flops before use
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Temperature sensor powers on when converter selects it or test bus selects it.
// - With shift on, range code picks one of four temperature ranges.
// - Shift off with range 10 gives absolute 0-341 K test mode.
// - When trim enable set, four-bit bandgap trim drives the reference.
// - Battery monitor runs only while its enable bit is one.
// - Battery low when measured code is at or below the threshold.
// - Low-battery event pulls interrupt line low only when interrupt enabled.
// - Enabled monitor in sleep starts the low-frequency RC oscillator.
// - Battery monitor powers on once per second for 250 us.
// - Four consecutive low readings needed before the interrupt is raised.
// - Level register returns latest five-bit code, upper three bits zero.
// - Battery volts equal 1.7 plus 0.05 times code.
// - Start bit begins conversion, self-clears after 350 us; read after.
module tsbm_top #(
  parameter int BAT_PERIOD_CYCLES = tsbm_pkg::BAT_PERIOD_CYCLES,
  parameter int BAT_WINDOW_CYCLES = tsbm_pkg::BAT_WINDOW_CYCLES,
  parameter int CONV_TIME_CYCLES  = tsbm_pkg::CONV_TIME_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        battery_monitor_enable,
  input  wire logic        battery_irq_enable,
  input  wire logic        sleep_mode,
  input  wire logic        atb_temp_select,
  input  wire logic        irq_status_read,
  output logic             temp_sensor_power,
  output logic      [1:0]  sensor_range,
  output logic             temperature_shift_enable,
  output logic             absolute_mode,
  output logic             bandgap_trim_enable,
  output logic      [3:0]  bandgap_trim,
  output logic      [7:0]  temp_value_offset,
  output logic      [2:0]  converter_input_select,
  output logic      [1:0]  converter_reference,
  output logic      [1:0]  converter_gain,
  output logic             converter_run,
  input  wire logic [7:0]  converter_result_in,
  output logic             battery_monitor_power,
  input  wire logic [4:0]  battery_code_in,
  output logic             lf_osc_enable,
  output logic             battery_event_flag,
  output logic             interrupt_request_n
);

  // Conversion timer width
  localparam int TW = $clog2(CONV_TIME_CYCLES + 1);

  // Register and pipeline state
  logic [6:0]  conv_cfg_q;
  logic        conv_busy_q;
  logic [TW-1:0] conv_cnt_q;
  logic [7:0]  conv_value_q;
  logic [7:0]  res_s1_q;
  logic [7:0]  res_s2_q;
  logic [7:0]  temp_ctrl_q;
  logic [7:0]  temp_offset_q;
  logic [4:0]  bat_thresh_q;
  logic [7:0]  rdata_q;
  logic        flag_q;
  logic        irq_n_q;
  logic [4:0]  bat_level;
  logic        bat_event;

  // Address decode shared by the write and read paths
  wire hit_conv_cfg = (reg_addr == tsbm_pkg::ADDR_CONV_CONFIG);
  wire hit_conv_val = (reg_addr == tsbm_pkg::ADDR_CONV_VALUE);
  wire hit_temp_ctl = (reg_addr == tsbm_pkg::ADDR_TEMP_CTRL);
  wire hit_temp_off = (reg_addr == tsbm_pkg::ADDR_TEMP_OFFSET);
  wire hit_bat_thr  = (reg_addr == tsbm_pkg::ADDR_BAT_THRESH);
  wire hit_bat_lvl  = (reg_addr == tsbm_pkg::ADDR_BAT_LEVEL);

  // Register write decode; result and level addresses take no writes
  wire wr_conv_cfg = reg_wr && hit_conv_cfg;
  wire wr_temp_ctl = reg_wr && hit_temp_ctl;
  wire wr_temp_off = reg_wr && hit_temp_off;
  wire wr_bat_thr  = reg_wr && hit_bat_thr;

  // Start refused while busy, so a running conversion is never cut short
  wire start_req   = wr_conv_cfg && reg_wdata[tsbm_pkg::CONV_START_BIT] && !conv_busy_q;
  wire conv_end    = conv_busy_q && (conv_cnt_q == TW'(CONV_TIME_CYCLES - 1));

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    hit_conv_cfg ? {conv_busy_q, conv_cfg_q} :
    hit_conv_val ? conv_value_q :
    hit_temp_ctl ? temp_ctrl_q :
    hit_temp_off ? temp_offset_q :
    hit_bat_thr  ? {3'h0, bat_thresh_q} :
    hit_bat_lvl  ? {3'h0, bat_level} :
    8'h00;

  // Software-written configuration
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_cfg_q    <= tsbm_pkg::RST_CONV_CONFIG[6:0];
      temp_ctrl_q   <= tsbm_pkg::RST_TEMP_CTRL;
      temp_offset_q <= tsbm_pkg::RST_TEMP_OFFSET;
      bat_thresh_q  <= tsbm_pkg::RST_BAT_THRESH;
    end else begin
      if (wr_conv_cfg) begin
        conv_cfg_q <= reg_wdata[6:0];
      end
      if (wr_temp_ctl) begin
        temp_ctrl_q <= reg_wdata;
      end
      if (wr_temp_off) begin
        temp_offset_q <= reg_wdata;
      end
      if (wr_bat_thr) begin
        bat_thresh_q <= reg_wdata[4:0];
      end
    end
  end

  // Two-flop capture of the converter result
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      res_s1_q <= 8'h00;
      res_s2_q <= 8'h00;
    end else begin
      res_s1_q <= converter_result_in;
      res_s2_q <= res_s1_q;
    end
  end

  // Conversion timer; start is ignored while busy
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_busy_q  <= 1'b0;
      conv_cnt_q   <= '0;
      conv_value_q <= 8'h00;
    end else if (start_req) begin
      conv_busy_q <= 1'b1;
      conv_cnt_q  <= '0;
    end else if (conv_end) begin
      conv_busy_q  <= 1'b0;
      conv_value_q <= res_s2_q;
    end else if (conv_busy_q) begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  // Registered read data, loaded on each read strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Battery sampling runs in its own block on the same clock
  tsbm_battery_sampler #(
    .PERIOD_CYCLES (BAT_PERIOD_CYCLES),
    .WINDOW_CYCLES (BAT_WINDOW_CYCLES)
  ) u_sampler (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .enable          (battery_monitor_enable),
    .threshold       (bat_thresh_q),
    .battery_code_in (battery_code_in),
    .monitor_power   (battery_monitor_power),
    .level           (bat_level),
    .low_event       (bat_event)
  );

  // Sticky event flag, set wins over clear; interrupt pin registered
  // Pin stays high while the interrupt enable is low, flag still kept
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q  <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      flag_q  <= bat_event || (flag_q && !irq_status_read);
      irq_n_q <= !(flag_q && battery_irq_enable);
    end
  end

  // Analog control outputs
  assign temp_sensor_power = (conv_cfg_q[tsbm_pkg::CONV_SEL_LSB +: 3] == tsbm_pkg::CONV_SEL_TEMP)
                             || atb_temp_select;
  assign sensor_range             = temp_ctrl_q[tsbm_pkg::TEMP_RANGE_LSB +: 2];
  assign temperature_shift_enable = temp_ctrl_q[tsbm_pkg::TEMP_SHIFT_BIT];
  assign absolute_mode            = !temp_ctrl_q[tsbm_pkg::TEMP_SHIFT_BIT]
                                    && (sensor_range == tsbm_pkg::RANGE_C_0_128);
  assign bandgap_trim_enable      = temp_ctrl_q[tsbm_pkg::TEMP_TRIM_EN_BIT];
  assign bandgap_trim             = bandgap_trim_enable ?
                                    temp_ctrl_q[tsbm_pkg::TEMP_TRIM_LSB +: 4] : 4'h0;
  assign temp_value_offset        = temp_offset_q;
  assign converter_input_select   = conv_cfg_q[tsbm_pkg::CONV_SEL_LSB +: 3];
  assign converter_reference      = conv_cfg_q[tsbm_pkg::CONV_REF_LSB +: 2];
  assign converter_gain           = conv_cfg_q[tsbm_pkg::CONV_GAIN_LSB +: 2];
  assign converter_run            = conv_busy_q;
  assign lf_osc_enable            = sleep_mode && battery_monitor_enable;
  assign battery_event_flag       = flag_q;
  assign interrupt_request_n      = irq_n_q;
  assign reg_rdata                = rdata_q;

endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Register and battery monitor scenarios for the block
// Assumes: Shortened period, window and conversion counts
// Notes:   Host model clears the interrupt
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic       ref_clk, resetn, reg_wr, reg_rd, battery_monitor_enable, battery_irq_enable;
  logic       sleep_mode, atb_temp_select, irq_status_read, temp_sensor_power, absolute_mode;
  logic       temperature_shift_enable, bandgap_trim_enable, converter_run, lf_osc_enable;
  logic       battery_monitor_power, battery_event_flag, interrupt_request_n;
  logic [1:0] sensor_range, converter_reference, converter_gain;
  logic [2:0] converter_input_select;
  logic [3:0] bandgap_trim;
  logic [4:0] battery_code_in;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, converter_result_in, ack_delay, temp_value_offset;
  int         mismatches, samples_checked, cycles;
  tsbm_top #(.BAT_PERIOD_CYCLES(200), .BAT_WINDOW_CYCLES(20), .CONV_TIME_CYCLES(30)) u_tsbm_top (
    .ref_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .battery_monitor_enable, .battery_irq_enable, .sleep_mode, .atb_temp_select,
    .irq_status_read, .temp_sensor_power, .sensor_range, .temperature_shift_enable,
    .absolute_mode, .bandgap_trim_enable, .bandgap_trim, .temp_value_offset,
    .converter_input_select, .converter_reference, .converter_gain, .converter_run,
    .converter_result_in, .battery_monitor_power, .battery_code_in, .lf_osc_enable,
    .battery_event_flag, .interrupt_request_n);
  tsbm_host_model u_tsbm_host_model (.ref_clk, .resetn, .interrupt_request_n, .ack_delay,
    .irq_status_read);
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Bus cycles and waits
  task automatic tick;
    @(posedge ref_clk) #2;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    tick();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    tick();
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic wait_window;
    for (int n = 0; n < 400 && battery_monitor_power !== 1'b1; n++) tick();
    for (int n = 0; n < 400 && battery_monitor_power !== 1'b0; n++) tick();
    repeat (3) tick();
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {reg_wr, reg_rd, battery_monitor_enable, battery_irq_enable} = 4'h0;
    {sleep_mode, atb_temp_select, resetn} = 3'h0;
    {reg_addr, reg_wdata} = 15'h0000;
    converter_result_in = 8'h9a;
    battery_code_in = 5'h0b;
    ack_delay = 8'h03;
    repeat (4) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    rdc(tsbm_pkg::ADDR_TEMP_CTRL, 8'h20);
    rdc(tsbm_pkg::ADDR_TEMP_OFFSET, 8'h00);
    wr(tsbm_pkg::ADDR_TEMP_OFFSET, 8'h5c);
    `CHK("temp_value_offset", 8'h5c, temp_value_offset)
    rdc(tsbm_pkg::ADDR_TEMP_OFFSET, 8'h5c);
    rdc(tsbm_pkg::ADDR_BAT_THRESH, 8'h14);
    rdc(7'h7f, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(tsbm_pkg::ADDR_TEMP_CTRL, {r[1:0], 6'h3a});
      `CHK("sensor_range", r[1:0], sensor_range)
      `CHK("temperature_shift_enable", 1'b1, temperature_shift_enable)
      `CHK("bandgap_trim", 4'ha, bandgap_trim)
    end
    wr(tsbm_pkg::ADDR_TEMP_CTRL, 8'h8a);
    `CHK("absolute_mode", 1'b1, absolute_mode)
    `CHK("temperature_shift_enable", 1'b0, temperature_shift_enable)
    `CHK("bandgap_trim", 4'h0, bandgap_trim)
    wr(tsbm_pkg::ADDR_BAT_THRESH, 8'hff);
    rdc(tsbm_pkg::ADDR_BAT_THRESH, 8'h1f);
    wr(tsbm_pkg::ADDR_TEMP_CTRL, 8'h20);
    wr(tsbm_pkg::ADDR_CONV_CONFIG, 8'h80);
    `CHK("temp_sensor_power", 1'b1, temp_sensor_power)
    `CHK("converter_run", 1'b1, converter_run)
    rdc(tsbm_pkg::ADDR_CONV_CONFIG, 8'h80);
    wr(tsbm_pkg::ADDR_CONV_CONFIG, 8'h80);
    for (int n = 0; n < 100 && converter_run !== 1'b0; n++) tick();
    rdc(tsbm_pkg::ADDR_CONV_CONFIG, 8'h00);
    rdc(tsbm_pkg::ADDR_CONV_VALUE, 8'h9a);
    `CHK("temp_celsius", 8'h0d, 8'(reg_rdata / 2 - 8'h40))
    wr(tsbm_pkg::ADDR_CONV_VALUE, 8'h55);
    rdc(tsbm_pkg::ADDR_CONV_VALUE, 8'h9a);
    wr(tsbm_pkg::ADDR_CONV_CONFIG, 8'h1b);
    `CHK("converter_input_select", 3'h1, converter_input_select)
    `CHK("converter_reference", 2'h2, converter_reference)
    `CHK("converter_gain", 2'h3, converter_gain)
    `CHK("temp_sensor_power", 1'b0, temp_sensor_power)
    atb_temp_select = 1'b1;
    tick();
    `CHK("temp_sensor_power", 1'b1, temp_sensor_power)
    wr(tsbm_pkg::ADDR_BAT_THRESH, 8'h0a);
    battery_monitor_enable = 1'b1;
    sleep_mode = 1'b1;
    tick();
    `CHK("lf_osc_enable", 1'b1, lf_osc_enable)
    sleep_mode = 1'b0;
    wait_window();
    rdc(tsbm_pkg::ADDR_BAT_LEVEL, 8'h0b);
    battery_code_in = 5'h0a;
    repeat (3) wait_window();
    `CHK("battery_event_flag", 1'b0, battery_event_flag)
    wait_window();
    `CHK("battery_event_flag", 1'b1, battery_event_flag)
    `CHK("interrupt_request_n", 1'b1, interrupt_request_n)
    battery_irq_enable = 1'b1;
    repeat (2) tick();
    `CHK("interrupt_request_n", 1'b0, interrupt_request_n)
    repeat (8) tick();
    `CHK("battery_event_flag", 1'b0, battery_event_flag)
    battery_irq_enable = 1'b0;
    battery_code_in = 5'h0b;
    wait_window();
    battery_code_in = 5'h0a;
    repeat (3) wait_window();
    `CHK("battery_event_flag", 1'b0, battery_event_flag)
    wait_window();
    `CHK("battery_event_flag", 1'b1, battery_event_flag)
    battery_monitor_enable = 1'b0;
    repeat (190) tick();
    `CHK("battery_monitor_power", 1'b0, battery_monitor_power)
    rdc(tsbm_pkg::ADDR_BAT_LEVEL, 8'h0a);
    print_verdict();
  end
endmodule
bind tsbm_top tsbm_checker_properties #(.WINDOW(BAT_WINDOW_CYCLES), .CONV(CONV_TIME_CYCLES))
  u_tsbm_checker_properties (.ref_clk, .resetn, .battery_monitor_enable, .battery_irq_enable,
  .sleep_mode, .atb_temp_select, .temp_sensor_power, .sensor_range, .temperature_shift_enable,
  .absolute_mode, .bandgap_trim_enable, .bandgap_trim, .converter_input_select, .converter_run,
  .battery_monitor_power, .lf_osc_enable, .battery_event_flag, .interrupt_request_n);
`default_nettype wire

// *** sim/tsbm_checker_properties.sv ***
// Purpose: Port checks for sensor control and battery monitor
// Assumes: One ref_clk domain, resetn active low
// Notes:   Window and conversion lengths arrive as parameters
`timescale 1ns/1ps
`default_nettype none
module tsbm_checker_properties #(
  parameter int WINDOW = 20,
  parameter int CONV   = 30
) (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       battery_monitor_enable,
  input wire logic       battery_irq_enable,
  input wire logic       sleep_mode,
  input wire logic       atb_temp_select,
  input wire logic       temp_sensor_power,
  input wire logic [1:0] sensor_range,
  input wire logic       temperature_shift_enable,
  input wire logic       absolute_mode,
  input wire logic       bandgap_trim_enable,
  input wire logic [3:0] bandgap_trim,
  input wire logic [2:0] converter_input_select,
  input wire logic       converter_run,
  input wire logic       battery_monitor_power,
  input wire logic       lf_osc_enable,
  input wire logic       battery_event_flag,
  input wire logic       interrupt_request_n
);
  logic [15:0] win_cnt_q;
  logic [15:0] run_cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Length of the current power window and conversion
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt_q <= '0;
      run_cnt_q <= '0;
    end else begin
      win_cnt_q <= battery_monitor_power ? win_cnt_q + 16'h0001 : '0;
      run_cnt_q <= converter_run ? run_cnt_q + 16'h0001 : '0;
    end
  end
  AST_SENSOR_POWER: assert property (temp_sensor_power ==
    (converter_input_select == 3'h0 || atb_temp_select)) else $error("sensor power wrong");
  AST_ABS_MODE: assert property (absolute_mode ==
    (!temperature_shift_enable && sensor_range == 2'h2)) else $error("absolute mode wrong");
  AST_TRIM_GATE: assert property (!bandgap_trim_enable |-> bandgap_trim == 4'h0)
    else $error("trim applied while disabled");
  AST_MON_OFF: assert property (!battery_monitor_enable |=> !battery_monitor_power)
    else $error("monitor powered while disabled");
  AST_LF_OSC: assert property (lf_osc_enable == (sleep_mode && battery_monitor_enable))
    else $error("low frequency oscillator wrong");
  AST_IRQ_FOLLOW: assert property (interrupt_request_n ==
    !($past(battery_event_flag) && $past(battery_irq_enable))) else $error("irq line wrong");
  AST_WINDOW_LEN: assert property (($fell(battery_monitor_power) &&
    $past(battery_monitor_enable)) |-> win_cnt_q == WINDOW) else $error("window length wrong");
  AST_CONV_LEN: assert property ($fell(converter_run) |->
    run_cnt_q == CONV) else $error("conversion length wrong");
  // Main scenarios reached
  cover property ($fell(interrupt_request_n));
  cover property ($fell(converter_run));
  cover property ($rose(battery_event_flag) && !battery_irq_enable);
endmodule
`default_nettype wire

// *** sim/tsbm_host_model.sv ***
// Purpose: Host side that answers the interrupt line
// Assumes: Interrupt line active low on ref_clk
// Notes:   Reads status once per interrupt after ack_delay cycles
`timescale 1ns/1ps
`default_nettype none
module tsbm_host_model (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       interrupt_request_n,
  input  wire logic [7:0] ack_delay,
  output var  logic       irq_status_read
);
  logic [7:0] cnt_q;
  logic       done_q;
  // Status read pulse, one per asserted interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      irq_status_read <= 1'b0;
    end else begin
      irq_status_read <= 1'b0;
      if (interrupt_request_n) begin
        cnt_q <= '0;
        done_q <= 1'b0;
      end else if (!done_q) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == ack_delay) begin
          irq_status_read <= 1'b1;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire
